// [hw/uart_interrupt_enable_status.sv]
// Interrupt mask, line status, modem deltas and prioritised source register.
// Assumes receiver, transmitter and FIFO logic share ref_clk; only the
// clear-to-send pin arrives from outside and is synchronised here.

`timescale 1ns/10ps
`default_nettype none

module uart_interrupt_enable_status #(
    parameter int LEVEL_W = 5,
    parameter int TIMER_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [uart_irq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fifo_en,
    input wire logic enhanced_en,
    input wire logic [7:0] rx_head_data,
    input wire logic [2:0] rx_head_err,
    input wire logic rx_char_loaded,
    input wire logic rx_fifo_empty,
    input wire logic [LEVEL_W-1:0] rx_fifo_level,
    input wire logic [LEVEL_W-1:0] rx_trigger_level,
    input wire logic rx_overrun_event,
    input wire logic rx_fifo_has_error,
    input wire logic bit_tick,
    input wire logic [3:0] char_bits,
    input wire logic thr_empty,
    input wire logic tx_all_empty,
    input wire logic [LEVEL_W-1:0] tx_fifo_level,
    input wire logic [LEVEL_W-1:0] tx_trigger_level,
    input wire logic [3:0] modem_lines,
    input wire logic [3:0] modem_change,
    input wire logic pause_detect,
    input wire logic resume_detect,
    input wire logic special_detect,
    input wire logic rts_pin,
    input wire logic cts_pin,
    input wire logic auto_rts_en,
    input wire logic auto_cts_en,
    output logic irq,
    output logic sleep_en,
    output logic rhr_read,
    output logic thr_write
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] rdata;
        logic ready;
        logic overrun;
        logic line_pend;
        logic to_pend;
        logic tx_pend;
        logic thr_empty_d;
        logic tx_below_d;
        logic tx_empty_d;
        logic [3:0] delta;
        logic pause;
        logic special;
        logic flow;
        logic rts_d;
        logic cts_s1;
        logic cts_s2;
        logic cts_d;
    } state_t;

    state_t r;
    state_t nxt;
    logic [uart_irq_pkg::SRC_N-1:0] pend;
    logic [5:0] code;
    logic to_expire;
    logic rd_src;
    logic rd_line;
    logic rd_modem;
    logic wr_mask;
    logic tx_below;
    logic tx_empty;
    logic [7:0] line_val;
    logic [7:0] mask_view;

    if (LEVEL_W < 4 || TIMER_W < 7) begin : g_width_check
        $error("uart_interrupt_enable_status: widths too small");
    end

    function automatic logic hit(input logic strobe, input logic [2:0] addr,
                                 input logic [2:0] off);
        hit = strobe && (addr == off);
    endfunction : hit

    // ------------------------------------------------------------
    // Decode and sources
    // ------------------------------------------------------------
    always_comb begin
        rhr_read = ce && hit(reg_rd, reg_addr, uart_irq_pkg::OFF_HOLDING);
        thr_write = ce && hit(reg_wr, reg_addr, uart_irq_pkg::OFF_HOLDING);
        rd_src = ce && hit(reg_rd, reg_addr, uart_irq_pkg::OFF_SOURCE);
        rd_line = ce && hit(reg_rd, reg_addr, uart_irq_pkg::OFF_LINE);
        rd_modem = ce && hit(reg_rd, reg_addr, uart_irq_pkg::OFF_MODEM);
        wr_mask = ce && hit(reg_wr, reg_addr, uart_irq_pkg::OFF_MASK);
        tx_below = tx_fifo_level < tx_trigger_level;
        tx_empty = tx_fifo_level == '0;
        sleep_en = r.mask[uart_irq_pkg::MB_SLEEP];
        // Upper mask bits are hidden unless the enhanced functions are on.
        mask_view = enhanced_en ? r.mask : (r.mask & uart_irq_pkg::MASK_BASIC);
        line_val = {rx_fifo_has_error,
                    tx_all_empty, thr_empty,
                    rx_head_err,
                    r.overrun,
                    r.ready};
    end

    always_comb begin
        pend = '0;
        pend[uart_irq_pkg::SRC_LINE] = r.line_pend && r.mask[uart_irq_pkg::MB_LINE];
        pend[uart_irq_pkg::SRC_TIMEOUT] = r.to_pend && r.mask[uart_irq_pkg::MB_RXD];
        if (fifo_en) begin
            pend[uart_irq_pkg::SRC_RXD] = r.mask[uart_irq_pkg::MB_RXD]
                && (rx_fifo_level >= rx_trigger_level);
        end else begin
            pend[uart_irq_pkg::SRC_RXD] = r.mask[uart_irq_pkg::MB_RXD] && r.ready;
        end
        pend[uart_irq_pkg::SRC_TX] = r.tx_pend && r.mask[uart_irq_pkg::MB_TX];
        pend[uart_irq_pkg::SRC_MODEM] = (|r.delta) && r.mask[uart_irq_pkg::MB_MODEM];
        pend[uart_irq_pkg::SRC_PAUSE] = (r.pause || r.special)
            && mask_view[uart_irq_pkg::MB_PAUSE];
        pend[uart_irq_pkg::SRC_FLOW] = r.flow
            && (mask_view[uart_irq_pkg::MB_RTS] || mask_view[uart_irq_pkg::MB_CTS]);
        // Clearing mask bits 0-3 leaves the status readable for polling.
        irq = |pend;
    end

    isr_priority u_prio (
        .pend(pend),
        .code(code)
    );

    rx_timeout_timer #(
        .CNT_W(TIMER_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .bit_tick(bit_tick),
        .char_bits(char_bits),
        .active(!rx_fifo_empty),
        .restart(rx_char_loaded || rhr_read),
        .expire(to_expire)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = r;
        if (ce) begin
            nxt.cts_s1 = cts_pin;
            nxt.cts_s2 = r.cts_s1;
            nxt.cts_d = r.cts_s2;
            nxt.rts_d = rts_pin;
            nxt.thr_empty_d = thr_empty;
            nxt.tx_below_d = tx_below;
            nxt.tx_empty_d = tx_empty;
            if (wr_mask) begin
                nxt.mask[3:0] = reg_wdata[3:0];
                if (enhanced_en) begin
                    nxt.mask[7:4] = reg_wdata[7:4];
                end
            end
            // Read data: captured from the state as it stands before any clear below.
            nxt.rdata = 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    uart_irq_pkg::OFF_HOLDING: nxt.rdata = rx_head_data;
                    uart_irq_pkg::OFF_MASK: nxt.rdata = mask_view;
                    uart_irq_pkg::OFF_SOURCE: nxt.rdata = {fifo_en, fifo_en, code};
                    uart_irq_pkg::OFF_LINE: nxt.rdata = line_val;
                    uart_irq_pkg::OFF_MODEM: nxt.rdata = {modem_lines, r.delta};
                    default: nxt.rdata = 8'h00;
                endcase
            end
            // Data ready: emptying clears it, a new character sets it and wins.
            if (rx_fifo_empty) begin
                nxt.ready = 1'b0;
            end
            if (rx_char_loaded) begin
                nxt.ready = 1'b1;
            end
            // Line status interrupt and overrun flag, cleared by reading.
            if (rd_line) begin
                nxt.overrun = 1'b0;
                nxt.line_pend = 1'b0;
            end
            if (rhr_read && !rx_fifo_empty && (|rx_head_err)) begin
                nxt.line_pend = 1'b1;
            end
            if (rx_overrun_event) begin
                nxt.overrun = 1'b1;
                nxt.line_pend = 1'b1;
            end
            // Receive timeout.
            if (rhr_read) begin
                nxt.to_pend = 1'b0;
            end
            if (to_expire) begin
                nxt.to_pend = 1'b1;
            end
            // Transmit ready: only the reported source is consumed by a read.
            if (thr_write || (rd_src && code == uart_irq_pkg::SRC_CODES[uart_irq_pkg::SRC_TX])) begin
                nxt.tx_pend = 1'b0;
            end
            if (fifo_en) begin
                if ((tx_below && !r.tx_below_d) || (tx_empty && !r.tx_empty_d)) begin
                    nxt.tx_pend = 1'b1;
                end
            end else if (thr_empty && !r.thr_empty_d) begin
                nxt.tx_pend = 1'b1;
            end
            if (wr_mask && reg_wdata[uart_irq_pkg::MB_TX] && !r.mask[uart_irq_pkg::MB_TX]
                && thr_empty) begin
                nxt.tx_pend = 1'b1;
            end
            // Modem deltas and flow-control changes, cleared by reading.
            if (rd_modem) begin
                nxt.delta = 4'h0;
                nxt.flow = 1'b0;
            end
            nxt.delta = nxt.delta | modem_change;
            if (auto_rts_en && rts_pin && !r.rts_d) begin
                nxt.flow = 1'b1;
            end
            if (auto_cts_en && r.cts_s2 && !r.cts_d) begin
                nxt.flow = 1'b1;
            end
            // Pause and special character.
            if (rd_src && code == uart_irq_pkg::SRC_CODES[uart_irq_pkg::SRC_PAUSE]) begin
                nxt.pause = 1'b0;
                nxt.special = 1'b0;
            end
            if (resume_detect) begin
                nxt.pause = 1'b0;
            end
            if (rx_char_loaded && r.special) begin
                nxt.special = 1'b0;
            end
            if (pause_detect) begin
                nxt.pause = 1'b1;
            end
            if (special_detect) begin
                nxt.special = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.mask <= uart_irq_pkg::MASK_RESET;
        end else begin
            r <= nxt;
        end
    end

    assign reg_rdata = r.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_mask_hold: assert property (!wr_mask |=> r.mask == $past(r.mask))
        else $error("Mask changed without a write.");
    a_rx_level: assert property (rd_src && fifo_en && r.mask[0] && !pend[0] && !pend[1]
        && (rx_fifo_level >= rx_trigger_level) |=> reg_rdata[5:0] == 6'h04)
        else $error("Receive level interrupt wrong.");
    a_ready_set: assert property (ce && rx_char_loaded |=> r.ready)
        else $error("Data ready not set.");
    a_overrun_read: assert property (ce && rx_overrun_event |=>
        line_val[1] && r.line_pend)
        else $error("Overrun not reported.");
    a_line_clear: assert property (rd_line && !rx_overrun_event && !rhr_read |=>
        !r.line_pend)
        else $error("Line interrupt not cleared.");
    a_tx_enable: assert property (wr_mask && reg_wdata[1] && !r.mask[1] && thr_empty |=>
        r.tx_pend ##0 irq)
        else $error("Transmit enable did not interrupt.");
    a_tx_clear: assert property (
        thr_write && !fifo_en && !(thr_empty && !r.thr_empty_d) |=> !r.tx_pend)
        else $error("Transmit ready not cleared.");
    a_none_code: assert property (rd_src && pend == '0 |=> reg_rdata[5:0] == 6'h01)
        else $error("Idle source code wrong.");
    a_line_first: assert property (rd_src && pend[0] |=> reg_rdata[5:0] == 6'h06)
        else $error("Line status not highest.");
    a_timeout_clr: assert property (rhr_read && !to_expire |=> !r.to_pend)
        else $error("Timeout not cleared.");
    a_irq_idle: assert property (r.mask == 8'h00 |-> !irq)
        else $error("Interrupt without a source.");
    a_rts_rise: assert property (ce && auto_rts_en && rts_pin && !r.rts_d |=>
        r.flow)
        else $error("Flow change missed.");
    a_modem_clr: assert property (rd_modem && modem_change == 4'h0 |=> r.delta == 4'h0)
        else $error("Modem delta not cleared.");

    c_timeout: cover property (to_expire ##[1:50] rhr_read);
    c_tx_cycle: cover property (r.tx_pend && irq ##[1:20] thr_write);
    c_flow_read: cover property (r.flow ##[1:20] rd_modem);
endmodule : uart_interrupt_enable_status

`default_nettype wire

// [common/uart_irq_pkg.sv]
// Contract
// - FIFO-mode receive interrupt follows trigger level.
// - Data-ready set on load, cleared when empty.
// - Masks 0-3 clear gives polled mode.
// - Overrun sets line status bit 1.
// - Bits 2-4 show head character errors.
// - Bit 5 holding empty, bit 6 all empty.
// - Bit 7 flags any errored FIFO character.
// - Mask bit 0 enables receive data interrupt.
// - Mask bit 1 enables transmit ready interrupt.
// - Mask bit 2 enables line status interrupt.
// - Mask bit 3 enables modem status interrupt.
// - Mask bits 4-7 need enhanced enable.
// - Mask bit 5 enables pause/special interrupt.
// - Mask bit 6 enables request-to-send rise interrupt.
// - Mask bit 7 enables clear-to-send rise interrupt.
// - Mask register resets to zero.
// - Source register reports highest pending code.
// - Timeout after four chars plus twelve bits.
// - Transmit ready cleared by source read, write.
// - Line/modem interrupts cleared by their reads.
// - Flow interrupts cleared by modem status read.
// - Pause/special cleared by read, resume, char.
// - Source bit 0 high when none pending.
// - Fixed priority order with fixed codes.
//
// Shared constants of the channel interrupt block.
// Assumes a 3-bit register address from the host port.

`default_nettype none

package uart_irq_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_HOLDING = 3'h0;
    localparam logic [2:0] OFF_MASK = 3'h1;
    localparam logic [2:0] OFF_SOURCE = 3'h2;
    localparam logic [2:0] OFF_LINE = 3'h5;
    localparam logic [2:0] OFF_MODEM = 3'h6;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int MB_RXD = 0;
    localparam int MB_TX = 1;
    localparam int MB_LINE = 2;
    localparam int MB_MODEM = 3;
    localparam int MB_SLEEP = 4;
    localparam int MB_PAUSE = 5;
    localparam int MB_RTS = 6;
    localparam int MB_CTS = 7;
    localparam logic [7:0] MASK_BASIC = 8'h0F;
    localparam int SRC_N = 7;
    localparam int SRC_LINE = 0;
    localparam int SRC_TIMEOUT = 1;
    localparam int SRC_RXD = 2;
    localparam int SRC_TX = 3;
    localparam int SRC_MODEM = 4;
    localparam int SRC_PAUSE = 5;
    localparam int SRC_FLOW = 6;
    localparam logic [5:0] CODE_NONE = 6'h01;
    localparam logic [SRC_N-1:0][5:0] SRC_CODES = {6'h20, 6'h10, 6'h00, 6'h02, 6'h04, 6'h0C,
        6'h06};
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_BITS = 12;
endpackage : uart_irq_pkg

`default_nettype wire

// [hw/isr_priority.sv]
// Picks the highest pending interrupt source and forms its code.
// Assumes pending bits are already gated by their masks.

`timescale 1ns/10ps
`default_nettype none

module isr_priority (
    input wire logic [uart_irq_pkg::SRC_N-1:0] pend,
    output logic [5:0] code
);
    always_comb begin
        code = uart_irq_pkg::CODE_NONE;
        // Index 0 is the highest level, so it is visited last and wins.
        for (int i = uart_irq_pkg::SRC_N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                code = uart_irq_pkg::SRC_CODES[i];
            end
        end
    end
endmodule : isr_priority

`default_nettype wire

// [hw/rx_timeout_timer.sv]
// Receive timeout delay timer counted in bit ticks.
// Assumes bit_tick is a one-cycle strobe per bit time on ref_clk.

`timescale 1ns/10ps
`default_nettype none

module rx_timeout_timer #(
    parameter int CNT_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bit_tick,
    input wire logic [3:0] char_bits,
    input wire logic active,
    input wire logic restart,
    output logic expire
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic fired;
    } tmr_t;

    tmr_t r;
    tmr_t nxt;
    logic [CNT_W-1:0] limit;

    // The longest delay, four 15-bit characters plus twelve bits, needs seven counter bits.
    if (CNT_W < 7) begin : g_cnt_check
        $error("rx_timeout_timer: CNT_W too small for the delay");
    end

    always_comb begin
        limit = CNT_W'(uart_irq_pkg::TIMEOUT_CHARS * char_bits + uart_irq_pkg::TIMEOUT_BITS);
        nxt = r;
        expire = 1'b0;
        if (ce) begin
            if (restart || !active) begin
                nxt.cnt = '0;
                nxt.fired = 1'b0;
            end else if (bit_tick && !r.fired) begin
                nxt.cnt = r.cnt + 1'b1;
                if (r.cnt + 1'b1 >= limit) begin
                    nxt.fired = 1'b1;
                    expire = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end
endmodule : rx_timeout_timer

`default_nettype wire

// [tb/host_bus_model.sv]
// Host processor model: performs single-cycle register writes and reads.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input wire logic ref_clk,
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Released write data are inverted so a stale value is never mistaken for a live one.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : host_bus_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the channel interrupt mask and source logic.
// Assumes host_bus_model drives the register port; all other inputs come from here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce, fifo_en, enhanced_en, rx_fifo_empty, rx_fifo_has_error, bit_tick;
    logic thr_empty, tx_all_empty, rts_pin, cts_pin, auto_rts_en, auto_cts_en;
    logic [7:0] rx_head_data, reg_wdata, reg_rdata, rd_d;
    logic [2:0] rx_head_err, reg_addr;
    logic [3:0] char_bits, modem_lines, mc;
    logic [4:0] rx_fifo_level, rx_trigger_level, tx_fifo_level, tx_trigger_level;
    logic [4:0] ev;
    logic reg_wr, reg_rd, irq, sleep_en, rhr_rd, thr_wr;
    logic [6:0] pm = 7'h00;
    logic [7:0] mm = 8'h00;
    int codes[7] = '{6, 12, 4, 2, 0, 16, 32};
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int rhr_n = 0;
    int thr_n = 0;
    always #12.5 ref_clk = ~ref_clk;
    host_bus_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    uart_interrupt_enable_status uut (.ref_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fifo_en, .enhanced_en, .rx_head_data, .rx_head_err,
        .rx_char_loaded(ev[0]), .rx_fifo_empty, .rx_fifo_level, .rx_trigger_level,
        .rx_overrun_event(ev[1]), .rx_fifo_has_error, .bit_tick, .char_bits, .thr_empty,
        .tx_all_empty, .tx_fifo_level, .tx_trigger_level, .modem_lines, .modem_change(mc),
        .pause_detect(ev[2]), .resume_detect(ev[3]), .special_detect(ev[4]), .rts_pin,
        .cts_pin, .auto_rts_en, .auto_cts_en, .irq, .sleep_en, .rhr_read(rhr_rd),
        .thr_write(thr_wr));
    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    function automatic int top_idx();
        logic [6:0] en;
        en = pm & {mm[6] | mm[7], mm[5], mm[3], mm[1], mm[0], mm[0], mm[2]};
        for (int i = 0; i < 7; i++) if (en[i]) return i;
        return -1;
    endfunction : top_idx
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_irq();
        @(negedge ref_clk);
        chk_reg({7'h00, irq}, {7'h00, top_idx() >= 0});
    endtask : chk_irq
    // Reading the source clears transmit and pause flags only when they are reported.
    task automatic chk_src();
        int k;
        logic [5:0] c;
        k = top_idx();
        c = (k < 0) ? 6'h01 : 6'(codes[k]);
        host.rd(uart_irq_pkg::OFF_SOURCE, rd_d);
        chk_reg(rd_d, {fifo_en, fifo_en, c});
        if (k == 3 || k == 5) pm[k] = 1'b0;
    endtask : chk_src
    task automatic wm(input logic [7:0] d);
        host.wr(uart_irq_pkg::OFF_MASK, d);
        mm = enhanced_en ? d : (d & 8'h0F);
    endtask : wm
    task automatic pulse(input logic [4:0] e, input logic [3:0] m);
        @(posedge ref_clk);
        ev <= e;
        mc <= m;
        @(posedge ref_clk);
        ev <= 5'h00;
        mc <= 4'h0;
    endtask : pulse
    // The run is cut short well beyond its expected length of under a thousand cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (rhr_rd) rhr_n++;
        if (thr_wr) thr_n++;
        if (cycles == 4000) begin
            failures++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        {ce, fifo_en, enhanced_en, rx_fifo_has_error, bit_tick, thr_empty} = 6'b100000;
        {rx_fifo_empty, tx_all_empty, rts_pin, cts_pin, auto_rts_en, auto_cts_en} = 6'b110000;
        {rx_head_err, ev, mc, char_bits} = {3'h0, 5'h00, 4'h0, 4'hA};
        {rx_fifo_level, rx_trigger_level, tx_fifo_level, tx_trigger_level} = 20'h01001;
        void'($urandom(32'hC8DA9B97));
        rx_head_data = 8'($urandom);
        modem_lines = 4'($urandom);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        host.rd(uart_irq_pkg::OFF_MASK, rd_d);
        chk_reg(rd_d, 8'h00);
        chk_src();
        chk_irq();
        wm(8'hFF);
        host.rd(uart_irq_pkg::OFF_MASK, rd_d);
        chk_reg(rd_d, mm);
        wm(8'h00);
        @(posedge ref_clk) enhanced_en <= 1'b1;
        wm(8'h10);
        @(negedge ref_clk) chk_reg({7'h00, sleep_en}, 8'h01);
        @(posedge ref_clk) thr_empty <= 1'b1;
        wm(8'h02);
        pm[3] = 1'b1;
        chk_irq();
        chk_src();
        chk_src();
        wm(8'h00);
        wm(8'h02);
        pm[3] = 1'b1;
        host.wr(uart_irq_pkg::OFF_HOLDING, rx_head_data);
        pm[3] = 1'b0;
        chk_irq();
        wm(8'h00);
        wm(8'h06);
        pm[3] = 1'b1;
        @(posedge ref_clk);
        rx_fifo_empty <= 1'b0;
        rx_fifo_has_error <= 1'b1;
        rx_head_err <= 3'h5;
        pulse(5'h03, 4'h0);
        pm[0] = 1'b1;
        chk_src();
        host.rd(uart_irq_pkg::OFF_LINE, rd_d);
        pm[0] = 1'b0;
        chk_reg(rd_d, 8'hF7);
        chk_src();
        chk_src();
        host.rd(uart_irq_pkg::OFF_HOLDING, rd_d);
        pm[0] = 1'b1;
        chk_reg(rd_d, rx_head_data);
        chk_src();
        host.rd(uart_irq_pkg::OFF_LINE, rd_d);
        pm[0] = 1'b0;
        @(posedge ref_clk);
        rx_head_err <= 3'h0;
        rx_fifo_empty <= 1'b1;
        host.rd(uart_irq_pkg::OFF_LINE, rd_d);
        chk_reg(rd_d & 8'h01, 8'h00);
        @(posedge ref_clk);
        fifo_en <= 1'b1;
        rx_fifo_empty <= 1'b0;
        rx_fifo_level <= 5'h03;
        rx_trigger_level <= 5'h04;
        wm(8'h01);
        chk_src();
        @(posedge ref_clk) rx_fifo_level <= 5'h04;
        pm[2] = 1'b1;
        chk_src();
        @(posedge ref_clk) rx_fifo_level <= 5'h03;
        pm[2] = 1'b0;
        chk_irq();
        @(posedge ref_clk) bit_tick <= 1'b1;
        pulse(5'h01, 4'h0);
        repeat (4 * 10 + 12 - 3) @(posedge ref_clk);
        chk_irq();
        repeat (6) @(posedge ref_clk);
        bit_tick <= 1'b0;
        pm[1] = 1'b1;
        chk_src();
        host.rd(uart_irq_pkg::OFF_HOLDING, rd_d);
        pm[1] = 1'b0;
        chk_irq();
        wm(8'h20);
        pulse(5'h04, 4'h0);
        pm[5] = 1'b1;
        chk_src();
        pulse(5'h04, 4'h0);
        pm[5] = 1'b1;
        chk_irq();
        pulse(5'h08, 4'h0);
        pm[5] = 1'b0;
        chk_irq();
        pulse(5'h10, 4'h0);
        pm[5] = 1'b1;
        chk_irq();
        pulse(5'h01, 4'h0);
        pm[5] = 1'b0;
        chk_irq();
        wm(8'h08);
        pulse(5'h00, 4'h5);
        pm[4] = 1'b1;
        chk_src();
        host.rd(uart_irq_pkg::OFF_MODEM, rd_d);
        pm[4] = 1'b0;
        chk_reg(rd_d, {modem_lines, 4'h5});
        chk_irq();
        wm(8'hC0);
        @(posedge ref_clk) auto_rts_en <= 1'b1;
        @(posedge ref_clk) rts_pin <= 1'b1;
        pm[6] = 1'b1;
        chk_src();
        host.rd(uart_irq_pkg::OFF_MODEM, rd_d);
        pm[6] = 1'b0;
        chk_irq();
        @(posedge ref_clk) auto_cts_en <= 1'b1;
        @(posedge ref_clk) cts_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pm[6] = 1'b1;
        chk_irq();
        host.rd(uart_irq_pkg::OFF_MODEM, rd_d);
        pm[6] = 1'b0;
        chk_irq();
        wm(8'h00);
        chk_irq();
        chk_reg(8'(rhr_n), 8'h02);
        chk_reg(8'(thr_n), 8'h01);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
